// file: design/fault_inject_recovery_defs.vh
// Overview of operation
// RULE_01: An injected fault trigger stays present while the manager holds its request bit set and drops when it is cleared.
// RULE_02: Injected faults run through the same detection, shutdown and reporting path as genuine faults.
// RULE_03: Any fault is propagated to the group line and shuts the converter down per its configured response. Code drives it only per propagate_cfg_in.
// RULE_04: After a non-latching trigger clears, the converter waits a 130 ms hiccup timeout and restarts on its own.
// RULE_05: Members shut down by a propagated non-latching fault restart when the faulted converter restarts.
// RULE_06: Clearing a latching fault trigger leaves the converter off with the latched state retained.
// RULE_07: A latched fault clears on an enable toggle or on a turn-off followed by a turn-on command.
// RULE_08: The single-wire link carries both switching synchronisation and command and status traffic. Code has separate sync and command inputs.
// RULE_09: Each converter's group fault line is wired to the shared line of its assigned group.
// RULE_10: One injection request bit per fault type, set over the link, is ORed into the real detector output.
`ifndef FAULT_INJECT_RECOVERY_DEFS_VH
`define FAULT_INJECT_RECOVERY_DEFS_VH
`define FAULT_TYPES 4
`define FT_OVER_TEMPERATURE 2
`define CLOCK_HZ 10000000
`define HICCUP_TIME_MS 130
// 130 ms at 10 MHz, sized to the counter width
`define HICCUP_CYCLES 24'h13D620
`define LINK_CMD_W 4
`define CMD_NONE 4'h0
`define CMD_TURN_OFF 4'h1
`define CMD_TURN_ON 4'h2
`define CMD_INJECT_SET 4'h3
`define CMD_INJECT_CLR 4'h4
`define CMD_GROUP_OFF 4'h5
`define CMD_GROUP_ON 4'h6
`define CNT_W 24
`endif

// file: design/fault_latch.v
`timescale 1ns/1ps
`include "fault_inject_recovery_defs.vh"
module fault_latch (
   input wire clock_in,
   input wire reset_n_in,
   input wire trigger_in,
   input wire clear_in,
   output reg held_out
);
   // Set wins over clear so a live trigger is never lost
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         held_out <= 1'b0;
      end else if (trigger_in) begin
         held_out <= 1'b1; // see RULE_06
      end else if (clear_in) begin
         held_out <= 1'b0; // see RULE_07
      end
   end
endmodule

// file: design/fault_inject_recovery.v
`timescale 1ns/1ps
`include "fault_inject_recovery_defs.vh"
module fault_inject_recovery #(
   parameter [`CNT_W-1:0] HICCUP_CYCLES = `HICCUP_CYCLES
) (
   input wire clock_in,
   input wire reset_n_in,
   input wire link_sync_in,
   input wire link_cmd_valid_in,
   input wire [`LINK_CMD_W-1:0] link_cmd_in,
   input wire [1:0] link_cmd_arg_in,
   input wire [`FAULT_TYPES-1:0] real_fault_in,
   input wire [`FAULT_TYPES-1:0] latching_cfg_in,
   input wire [`FAULT_TYPES-1:0] propagate_cfg_in,
   input wire enable_in,
   input wire group_fault_in,
   output wire group_fault_oe_n_out,
   output reg converter_run_out,
   output reg switch_sync_out,
   output reg [`FAULT_TYPES-1:0] fault_status_out,
   output reg latched_out
);
   localparam ST_OFF = 2'h0;
   localparam ST_RUN = 2'h1;
   localparam ST_FAULT = 2'h2;
   localparam ST_HICCUP = 2'h3;

   ////////////////////////////////////////////////////////////////////
   reg [`FAULT_TYPES-1:0] inject_q;
   reg [1:0] state_q;
   reg [`CNT_W-1:0] count_q;
   reg on_cmd_q;
   reg off_seen_q;
   reg enable_q;
   reg group_drive_q;
   wire [`FAULT_TYPES-1:0] trigger;
   wire [`FAULT_TYPES-1:0] held;
   wire any_nonlatch;
   wire any_latch;
   wire any_trigger;
   wire cmd_off;
   wire cmd_on;
   wire enable_toggle;
   wire latch_clear;

   // Injection requests held until cleared, one per fault type
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         inject_q <= {`FAULT_TYPES{1'b0}};
      end else if (link_cmd_valid_in && link_cmd_in == `CMD_INJECT_SET) begin
         inject_q[link_cmd_arg_in] <= 1'b1; // see RULE_01
      end else if (link_cmd_valid_in && link_cmd_in == `CMD_INJECT_CLR) begin
         inject_q[link_cmd_arg_in] <= 1'b0; // see RULE_01
      end
   end

   // Same path as genuine detection; nothing marks a fault as injected
   assign trigger = real_fault_in | inject_q; // see RULE_10, see RULE_02

   assign cmd_off = link_cmd_valid_in &&
      (link_cmd_in == `CMD_TURN_OFF || link_cmd_in == `CMD_GROUP_OFF);
   assign cmd_on = link_cmd_valid_in &&
      (link_cmd_in == `CMD_TURN_ON || link_cmd_in == `CMD_GROUP_ON);
   assign enable_toggle = enable_in != enable_q;
   // Off clears the latch; the following on restarts
   assign latch_clear = cmd_off || enable_toggle; // see RULE_07

   genvar i;
   generate
      for (i = 0; i < `FAULT_TYPES; i = i + 1) begin : g_lat
         fault_latch u_latch (
            .clock_in(clock_in),
            .reset_n_in(reset_n_in),
            .trigger_in(trigger[i] & latching_cfg_in[i]),
            .clear_in(latch_clear),
            .held_out(held[i])
         );
      end
   endgenerate

   assign any_latch = |held; // see RULE_06
   assign any_nonlatch = |(trigger & ~latching_cfg_in);
   assign any_trigger = |trigger;

   ////////////////////////////////////////////////////////////////////
   // Recovery state machine
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ST_OFF;
         count_q <= {`CNT_W{1'b0}};
         on_cmd_q <= 1'b0;
         off_seen_q <= 1'b0;
         enable_q <= 1'b0;
      end else begin
         enable_q <= enable_in;
         if (cmd_off) begin
            off_seen_q <= 1'b1;
         end else if (cmd_on) begin
            off_seen_q <= 1'b0;
         end
         if (cmd_on) begin
            on_cmd_q <= 1'b1;
         end else if (cmd_off) begin
            on_cmd_q <= 1'b0;
         end
         case (state_q)
            ST_OFF: begin
               if (any_trigger || any_latch || group_fault_in) begin
                  state_q <= ST_FAULT;
               end else if (enable_in && (on_cmd_q || cmd_on)) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (any_trigger || group_fault_in) begin
                  state_q <= ST_FAULT; // see RULE_03
               end else if (cmd_off || !enable_in) begin
                  state_q <= ST_OFF;
               end
            end
            ST_FAULT: begin
               // Latched: stays off even once the trigger is gone
               if (any_latch) begin
                  state_q <= ST_FAULT; // see RULE_06
               end else if (off_seen_q && !any_trigger) begin
                  state_q <= ST_OFF; // see RULE_07
               end else if (!any_nonlatch && !group_fault_in) begin
                  state_q <= ST_HICCUP;
                  count_q <= {`CNT_W{1'b0}};
               end
            end
            ST_HICCUP: begin
               if (any_trigger || any_latch) begin
                  state_q <= ST_FAULT;
               end else if (count_q >= HICCUP_CYCLES - 1'b1) begin
                  // Members restart here too; the line was already released when the trigger cleared
                  state_q <= ST_RUN; // see RULE_04, see RULE_05
               end else begin
                  count_q <= count_q + 1'b1; // see RULE_04
               end
            end
            default: begin
               state_q <= ST_OFF;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs registered; group line is open drain, low while driving
   always @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         converter_run_out <= 1'b0;
         switch_sync_out <= 1'b0;
         fault_status_out <= {`FAULT_TYPES{1'b0}};
         latched_out <= 1'b0;
         group_drive_q <= 1'b0;
      end else begin
         converter_run_out <= state_q == ST_RUN;
         switch_sync_out <= link_sync_in; // see RULE_08
         fault_status_out <= trigger | held; // see RULE_02
         latched_out <= any_latch;
         // Own triggers only, so a member never holds the line itself
         group_drive_q <= |((trigger | held) & propagate_cfg_in); // see RULE_03, see RULE_09
      end
   end

   assign group_fault_oe_n_out = ~group_drive_q;
endmodule

// file: dv/fir_checker_assertions.sv
`timescale 1ns/1ps
`include "fault_inject_recovery_defs.vh"
module fir_checker #(parameter [`CNT_W-1:0] HICCUP_CYCLES = 24'h000014) (
   input wire clock_in, reset_n_in, link_sync_in, link_cmd_valid_in,
   input wire [`LINK_CMD_W-1:0] link_cmd_in,
   input wire [1:0] link_cmd_arg_in,
   input wire [`FAULT_TYPES-1:0] real_fault_in, latching_cfg_in,
   input wire [`FAULT_TYPES-1:0] propagate_cfg_in, fault_status_out,
   input wire enable_in, group_fault_in, group_fault_oe_n_out,
   input wire converter_run_out, switch_sync_out, latched_out);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   wire cmd_v = link_cmd_valid_in;
   a_sync_copy: assert property (
      $changed(link_sync_in) && $past(reset_n_in) |=>
      switch_sync_out == $past(link_sync_in)) else $error("sync lost");
   a_inject_seen: assert property (
      cmd_v && link_cmd_in == `CMD_INJECT_SET && link_cmd_arg_in == 2'h2
      |-> ##2 fault_status_out[2]) else $error("inject unseen");
   a_fault_stops: assert property (
      |real_fault_in |-> ##[1:2] !converter_run_out) else $error("no stop");
   a_fault_drives: assert property (
      |(real_fault_in & propagate_cfg_in) |-> ##[1:2] !group_fault_oe_n_out)
      else $error("no propagate");
   a_latch_off: assert property (
      latched_out |-> !converter_run_out) else $error("run while latched");
   a_hiccup_wait: assert property (
      $fell(|fault_status_out) && !$past(latched_out) |=>
      !converter_run_out [*8]) else $error("hiccup short");
   a_group_stop: assert property (
      group_fault_in |-> ##[1:2] !converter_run_out) else $error("group run");
   a_on_refused: assert property (
      cmd_v && link_cmd_in == `CMD_TURN_ON && latched_out |=>
      !converter_run_out) else $error("on not refused");
   c_restart: cover property ($rose(converter_run_out));
   c_latched: cover property ($rose(latched_out));
   c_driven: cover property ($fell(group_fault_oe_n_out));
endmodule
bind fault_inject_recovery fir_checker
   #(.HICCUP_CYCLES(HICCUP_CYCLES)) chk_u (.*);

// file: dv/power_manager_model.sv
`timescale 1ns/1ps
module power_manager_model (
   input wire clock_in,
   output reg sync_out,
   output reg cmd_valid_out,
   output reg [3:0] cmd_out,
   output reg [1:0] arg_out);
   initial begin
      sync_out = 1'b0;
      cmd_valid_out = 1'b0;
      cmd_out = 4'h0;
      arg_out = 2'h0;
   end
   // Sync runs free on its own output, apart from the command lines
   always @(posedge clock_in) sync_out <= ~sync_out;
   task send(input [3:0] c, input [1:0] a);
      begin
         @(posedge clock_in);
         cmd_valid_out <= 1'b1;
         cmd_out <= c;
         arg_out <= a;
         @(posedge clock_in);
         cmd_valid_out <= 1'b0;
         // Idle lines never repeat a stale command
         cmd_out <= ~c;
         arg_out <= ~a;
      end
   endtask
endmodule

// file: dv/fault_inject_recovery_test.sv
`timescale 1ns/1ps
`include "fault_inject_recovery_defs.vh"
module fault_inject_recovery_test;
   reg clock_in = 1'b0;
   reg reset_n_in = 1'b0;
   reg enable_in = 1'b1;
   reg group_fault_in = 1'b0;
   reg [3:0] real_fault_in = 4'h0;
   reg [3:0] latching_cfg_in = 4'h0;
   reg [3:0] propagate_cfg_in = 4'hF;
   wire sync, valid, oe_n, run, sw_sync, latched;
   wire [3:0] cmd, status;
   wire [1:0] arg;
   integer n_fail = 0, total_checks = 0, cyc = 0, i, k;
   reg [31:0] rng = 32'h9D3167D4;
   always #50 clock_in = ~clock_in;
   power_manager_model mgr_u (.clock_in(clock_in), .sync_out(sync),
      .cmd_valid_out(valid), .cmd_out(cmd), .arg_out(arg));
   fault_inject_recovery #(.HICCUP_CYCLES(24'h000014)) dut_u (
      .clock_in(clock_in), .reset_n_in(reset_n_in), .link_sync_in(sync),
      .link_cmd_valid_in(valid), .link_cmd_in(cmd), .link_cmd_arg_in(arg),
      .real_fault_in(real_fault_in), .latching_cfg_in(latching_cfg_in),
      .propagate_cfg_in(propagate_cfg_in), .enable_in(enable_in),
      .group_fault_in(group_fault_in), .group_fault_oe_n_out(oe_n),
      .converter_run_out(run), .switch_sync_out(sw_sync),
      .fault_status_out(status), .latched_out(latched));
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   task check(input string what, input [3:0] exp, input [3:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("mismatch %0s exp %h got %h", what, exp, got);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clock_in);
         #1;
      end
   endtask
   // Bounded at 40 ticks: hiccup of 20 plus 20 cycles of margin for pipeline
   task wait_run;
      for (i = 0; i < 40 && run !== 1'b1; i = i + 1) tick(1);
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail = n_fail + 1;
         close_out;
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock_in);
      reset_n_in <= 1'b1;
      mgr_u.send(`CMD_TURN_ON, 2'h0);
      wait_run;
      mgr_u.send(`CMD_INJECT_SET, 2'h2);
      tick(12);
      check("status", 4'h4, status);
      check("oe_n", 4'h0, {3'h0, oe_n});
      check("sync", {3'h0, ~sync}, {3'h0, sw_sync});
      mgr_u.send(`CMD_INJECT_CLR, 2'h2);
      tick(3);
      check("status", 4'h0, status);
      wait_run;
      check("hiccup", 4'h1, {3'h0, i >= 18});
      $display("inject test done");
      for (k = 0; k < 6; k = k + 1) begin
         rng = xs(rng);
         @(posedge clock_in);
         latching_cfg_in <= rng[3:0];
         real_fault_in <= 4'h1 << rng[5:4];
         tick(3);
         check("status", 4'h1 << rng[5:4], status);
         check("run", 4'h0, {3'h0, run});
         @(posedge clock_in);
         real_fault_in <= 4'h0;
         tick(3);
         if (rng[rng[5:4]]) begin
            check("latched", 4'h1, {3'h0, latched});
            mgr_u.send(`CMD_TURN_ON, 2'h0);
            if (rng[6]) begin
               @(posedge clock_in);
               enable_in <= 1'b0;
               @(posedge clock_in);
               enable_in <= 1'b1;
            end else begin
               mgr_u.send(`CMD_TURN_OFF, 2'h0);
               mgr_u.send(`CMD_TURN_ON, 2'h0);
            end
         end
         wait_run;
         check("run", 4'h1, {3'h0, run});
      end
      $display("random fault test done");
      @(posedge clock_in);
      group_fault_in <= 1'b1;
      tick(3);
      check("run", 4'h0, {3'h0, run});
      @(posedge clock_in);
      group_fault_in <= 1'b0;
      wait_run;
      check("run", 4'h1, {3'h0, run});
      $display("group test done");
      close_out;
   end
endmodule
